// File: dsg_top.sv
// Deep-sleep port clock gating and peripheral soft reset control.
// Assumes a simple strobe register port and same-clock companion inputs
// for the run and sleep gates, power mode, auto gating and capabilities.
//
// Contract
// - Gate bit one clocks unit, zero stops it
// - Access to gated-off unit raises bus fault
// - All gate bits reset to zero
// - Deep-sleep register applies while in deep sleep
// - Sleep registers act only with auto gating
// - Bits 0..4 gate ports A..E, read/write
// - Bits 31:5 read zero; software preserves them
// - Reset writes masked by capability bits
// - Bit 16 resets converter module 0
// - Bit 3 resets watchdog; others read zero
`timescale 1ns/1ps
module dsg_top #(
  parameter int NUM_PORTS_P = dsg_pkg::NUM_PORTS
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [dsg_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [dsg_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [dsg_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] RUN_PORT_CLOCK_GATE_IN,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] SLEEP_PORT_CLOCK_GATE_IN,
  input wire logic AUTO_CLOCK_GATING_ENABLE_IN,
  input wire logic SLEEP_MODE_IN,
  input wire logic DEEP_SLEEP_MODE_IN,
  input wire logic [dsg_pkg::DATA_W-1:0] CAPABILITIES_1_IN,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] PORT_ACCESS_IN,
  output logic [dsg_pkg::NUM_PORTS-1:0] PORT_CLK_EN_OUT,
  output logic [dsg_pkg::NUM_PORTS-1:0] PORT_FAULT_OUT,
  output logic ADC0_RESET_OUT,
  output logic WATCHDOG_RESET_OUT,
  output logic IRQ_OUT
);
  import dsg_pkg::*;

  // Whole register state of this module
  typedef struct packed {
    logic [NUM_PORTS-1:0] deep_port_clock_gate_r;
    logic adc0_rst_r;
    logic wdt_rst_r;
    logic [DATA_W-1:0] rdata_r;
  } dsg_top_state_t;

  dsg_top_state_t st_r;
  dsg_top_state_t st_nxt;
  dsg_mode_t mode;
  logic wr_deep_gate;
  logic wr_soft_reset;
  logic wr_int_status;
  logic wr_int_mask;
  logic [DATA_W-1:0] soft_reset_wmask;
  logic [DATA_W-1:0] soft_reset_cur;
  logic [DATA_W-1:0] soft_reset_new;
  logic [NUM_PORTS-1:0] port_en;
  logic [NUM_PORTS-1:0] port_fault;
  logic [NUM_PORTS-1:0] int_status;
  logic [NUM_PORTS-1:0] int_mask;
  logic irq;

  // Only the five documented port bits are served
  generate
    if (NUM_PORTS_P != NUM_PORTS) begin : g_bad_ports
      $error("dsg_top NUM_PORTS_P must equal the port gate field width");
    end
  endgenerate

  // Power mode; deep sleep takes priority over sleep
  always_comb begin
    if (DEEP_SLEEP_MODE_IN) begin
      mode = DSG_MODE_DEEP;
    end else if (SLEEP_MODE_IN) begin
      mode = DSG_MODE_SLEEP;
    end else begin
      mode = DSG_MODE_RUN;
    end
  end

  // Write decode, one strobe per register
  always_comb begin
    wr_deep_gate = 1'b0;
    wr_soft_reset = 1'b0;
    wr_int_status = 1'b0;
    wr_int_mask = 1'b0;
    if (REG_WR_IN && REG_ADDR_IN == OFS_DEEP_GATE) begin
      wr_deep_gate = 1'b1;
    end else if (REG_WR_IN && REG_ADDR_IN == OFS_SOFT_RESET_0) begin
      wr_soft_reset = 1'b1;
    end else if (REG_WR_IN && REG_ADDR_IN == OFS_INT_STATUS) begin
      wr_int_status = 1'b1;
    end else if (REG_WR_IN && REG_ADDR_IN == OFS_INT_MASK) begin
      wr_int_mask = 1'b1;
    end
  end

  // Soft reset image and the capability-masked write value
  always_comb begin
    soft_reset_cur = '0;
    soft_reset_cur[ADC0_RST_POS] = st_r.adc0_rst_r;
    soft_reset_cur[WDT_RST_POS] = st_r.wdt_rst_r;
    soft_reset_wmask = CAPABILITIES_1_IN & SOFT_RESET_IMPL_MASK;
    soft_reset_new = (soft_reset_cur & ~soft_reset_wmask)
                   | (REG_WDATA_IN & soft_reset_wmask);
  end

  // Next state: register writes and registered read data
  always_comb begin
    st_nxt = st_r;
    if (wr_deep_gate) begin
      // Only bits 4:0 are stored, the rest are not writable
      st_nxt.deep_port_clock_gate_r = REG_WDATA_IN[PORT_E_POS:PORT_A_POS];
    end
    if (wr_soft_reset) begin
      st_nxt.adc0_rst_r = soft_reset_new[ADC0_RST_POS];
      st_nxt.wdt_rst_r = soft_reset_new[WDT_RST_POS];
    end
    // Read data stands only in the cycle after the read strobe
    st_nxt.rdata_r = RDATA_RST;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == OFS_DEEP_GATE) begin
        st_nxt.rdata_r[PORT_E_POS:PORT_A_POS] = st_r.deep_port_clock_gate_r;
      end else if (REG_ADDR_IN == OFS_SOFT_RESET_0) begin
        st_nxt.rdata_r = soft_reset_cur;
      end else if (REG_ADDR_IN == OFS_INT_STATUS) begin
        st_nxt.rdata_r[NUM_PORTS-1:0] = int_status;
      end else if (REG_ADDR_IN == OFS_INT_MASK) begin
        st_nxt.rdata_r[NUM_PORTS-1:0] = int_mask;
      end else if (REG_ADDR_IN == OFS_GATE_STATUS) begin
        st_nxt.rdata_r[NUM_PORTS-1:0] = port_en;
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      st_r.deep_port_clock_gate_r <= DEEP_GATE_RST[NUM_PORTS-1:0];
      st_r.adc0_rst_r <= SOFT_RESET_RST[ADC0_RST_POS];
      st_r.wdt_rst_r <= SOFT_RESET_RST[WDT_RST_POS];
      st_r.rdata_r <= RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One gate cell per port, A at bit 0 up to E at bit 4
  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      dsg_gate_cell u_cell (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .mode_in(mode),
        .auto_clock_gating_enable_in(AUTO_CLOCK_GATING_ENABLE_IN),
        .run_en_in(RUN_PORT_CLOCK_GATE_IN[i]),
        .sleep_en_in(SLEEP_PORT_CLOCK_GATE_IN[i]),
        .deep_en_in(st_r.deep_port_clock_gate_r[i]),
        .access_in(PORT_ACCESS_IN[i]),
        .clk_en_out(port_en[i]),
        .fault_out(port_fault[i])
      );
    end
  endgenerate

  // Bus faults are the interrupt events
  dsg_irq #(
    .WIDTH(NUM_PORTS)
  ) u_irq (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .event_in(port_fault),
    .status_wr_in(wr_int_status),
    .mask_wr_in(wr_int_mask),
    .wdata_in(REG_WDATA_IN[NUM_PORTS-1:0]),
    .status_out(int_status),
    .mask_out(int_mask),
    .irq_out(irq)
  );

  // Outputs, each straight from a flip-flop
  assign REG_RDATA_OUT = st_r.rdata_r;
  assign PORT_CLK_EN_OUT = port_en;
  assign PORT_FAULT_OUT = port_fault;
  assign ADC0_RESET_OUT = st_r.adc0_rst_r;
  assign WATCHDOG_RESET_OUT = st_r.wdt_rst_r;
  assign IRQ_OUT = irq;
endmodule

// File: dsg_pkg.sv
// Package for the deep-sleep port clock gate and soft reset block.
// Assumes a 32-bit register port with byte offsets on a 12-bit address.
package dsg_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SOFT_RESET_0 = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_DEEP_GATE = 12'h128;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_GATE_STATUS = 12'h208;

  // Port gate field: ports A..E on bits 0..4
  localparam int NUM_PORTS = 5;
  localparam int PORT_A_POS = 0;
  localparam int PORT_E_POS = 4;

  // Soft reset field positions
  localparam int ADC0_RST_POS = 16;
  localparam int WDT_RST_POS = 3;
  localparam logic [DATA_W-1:0] SOFT_RESET_IMPL_MASK = 32'h0001_0008;

  // Reset values
  localparam logic [DATA_W-1:0] DEEP_GATE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SOFT_RESET_RST = 32'h0000_0000;
  localparam logic [NUM_PORTS-1:0] INT_STATUS_RST = 5'h00;
  localparam logic [NUM_PORTS-1:0] INT_MASK_RST = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Power modes seen by the gate selector
  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_t;

endpackage

// File: dsg_gate_cell.sv
// One port's clock enable selector and bus fault detector.
// Assumes all inputs are on SYS_CLK domain logic.
`timescale 1ns/1ps
module dsg_gate_cell (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dsg_pkg::dsg_mode_t mode_in,
  input wire logic auto_clock_gating_enable_in,
  input wire logic run_en_in,
  input wire logic sleep_en_in,
  input wire logic deep_en_in,
  input wire logic access_in,
  output logic clk_en_out,
  output logic fault_out
);
  import dsg_pkg::*;

  typedef struct packed {
    logic en_r;
    logic fault_r;
  } dsg_cell_state_t;

  dsg_cell_state_t st_r;
  dsg_cell_state_t st_nxt;

  // Pick enable by power mode when auto gating is on; fault when the applied clock is off
  always_comb begin
    st_nxt = st_r;
    st_nxt.en_r = run_en_in;
    if (auto_clock_gating_enable_in) begin
      case (mode_in)
        DSG_MODE_SLEEP: st_nxt.en_r = sleep_en_in;
        DSG_MODE_DEEP: st_nxt.en_r = deep_en_in;
        default: st_nxt.en_r = run_en_in;
      endcase
    end
    st_nxt.fault_r = access_in & ~st_r.en_r;
  end

  // State register, all gates off at reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_en_out = st_r.en_r;
  assign fault_out = st_r.fault_r;
endmodule

// File: dsg_irq.sv
// Sticky event status, mask and level interrupt.
// Assumes one-cycle write strobes from the register decoder.
`timescale 1ns/1ps
module dsg_irq #(
  parameter int WIDTH = 5
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic status_wr_in,
  input wire logic mask_wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic irq_out
);
  import dsg_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] status_r;
    logic [WIDTH-1:0] mask_r;
    logic irq_r;
  } dsg_irq_state_t;

  dsg_irq_state_t st_r;
  dsg_irq_state_t st_nxt;

  generate
    if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
      $error("dsg_irq WIDTH out of range");
    end
  endgenerate

  // Write one clears; a new event in the same cycle wins
  always_comb begin
    st_nxt = st_r;
    if (status_wr_in) begin
      st_nxt.status_r = st_r.status_r & ~wdata_in;
    end
    st_nxt.status_r = st_nxt.status_r | event_in;
    if (mask_wr_in) begin
      st_nxt.mask_r = wdata_in;
    end
    st_nxt.irq_r = |(st_nxt.status_r & st_nxt.mask_r);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status_out = st_r.status_r;
  assign mask_out = st_r.mask_r;
  assign irq_out = st_r.irq_r;
endmodule

// File: dsg_top_chk.sv
// Checker for the port gate and soft reset block.
// Bound to dsg_top; sees only its ports.
`timescale 1ns/1ps
module dsg_top_chk #(
  parameter int NUM_PORTS_P = 5
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [dsg_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [dsg_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [dsg_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] RUN_PORT_CLOCK_GATE_IN,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] SLEEP_PORT_CLOCK_GATE_IN,
  input wire logic AUTO_CLOCK_GATING_ENABLE_IN,
  input wire logic SLEEP_MODE_IN,
  input wire logic DEEP_SLEEP_MODE_IN,
  input wire logic [dsg_pkg::DATA_W-1:0] CAPABILITIES_1_IN,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] PORT_ACCESS_IN,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] PORT_CLK_EN_OUT,
  input wire logic [dsg_pkg::NUM_PORTS-1:0] PORT_FAULT_OUT,
  input wire logic ADC0_RESET_OUT,
  input wire logic WATCHDOG_RESET_OUT,
  input wire logic IRQ_OUT
);
  import dsg_pkg::*;
  logic wr_sr;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Soft reset write decode
  assign wr_sr = REG_WR_IN && REG_ADDR_IN == OFS_SOFT_RESET_0;
  // Gate selection, faults, register reads, soft reset writes, interrupt cause, reset values
  // Sampled reset guard: the release edge still shows reset outputs
  AST_RUN_SEL: assert property (RST_N_IN && !AUTO_CLOCK_GATING_ENABLE_IN |=>
    PORT_CLK_EN_OUT == $past(RUN_PORT_CLOCK_GATE_IN)) else $error("run gate lost");
  AST_SLP_SEL: assert property (RST_N_IN && AUTO_CLOCK_GATING_ENABLE_IN && SLEEP_MODE_IN
    && !DEEP_SLEEP_MODE_IN |=> PORT_CLK_EN_OUT == $past(SLEEP_PORT_CLOCK_GATE_IN))
    else $error("sleep gate lost");
  AST_FAULT: assert property (RST_N_IN |=>
    PORT_FAULT_OUT == $past(PORT_ACCESS_IN & ~PORT_CLK_EN_OUT)) else $error("bad fault");
  AST_GATE_RO: assert property (REG_RD_IN && REG_ADDR_IN == OFS_DEEP_GATE |=>
    REG_RDATA_OUT[31:5] == 27'h0) else $error("gate high bits set");
  AST_SR_RD: assert property (REG_RD_IN && REG_ADDR_IN == OFS_SOFT_RESET_0 |=>
    REG_RDATA_OUT == {15'h0, $past(ADC0_RESET_OUT), 12'h0, $past(WATCHDOG_RESET_OUT), 3'h0})
    else $error("soft reset readback");
  AST_ADC_WR: assert property (1'b1 |=> ADC0_RESET_OUT ==
    ($past(wr_sr && CAPABILITIES_1_IN[16]) ? $past(REG_WDATA_IN[16]) : $past(ADC0_RESET_OUT)))
    else $error("converter reset");
  AST_WDT_WR: assert property (1'b1 |=> WATCHDOG_RESET_OUT ==
    ($past(wr_sr && CAPABILITIES_1_IN[3]) ? $past(REG_WDATA_IN[3]) : $past(WATCHDOG_RESET_OUT)))
    else $error("watchdog reset");
  AST_IRQ_SRC: assert property ($rose(IRQ_OUT) |->
    $past(PORT_FAULT_OUT != 0 || REG_WR_IN && REG_ADDR_IN == OFS_INT_MASK))
    else $error("irq without cause");
  AST_RST_ZERO: assert property ($rose(RST_N_IN) |-> PORT_CLK_EN_OUT == 5'h00
    && !ADC0_RESET_OUT && !WATCHDOG_RESET_OUT) else $error("reset not zero");
  // Main scenarios
  cover property (PORT_FAULT_OUT != 5'h00);
  cover property ($rose(IRQ_OUT));
  cover property (DEEP_SLEEP_MODE_IN && PORT_CLK_EN_OUT != 5'h00);
endmodule

bind dsg_top dsg_top_chk #(.NUM_PORTS_P(NUM_PORTS_P)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .RUN_PORT_CLOCK_GATE_IN(RUN_PORT_CLOCK_GATE_IN),
  .SLEEP_PORT_CLOCK_GATE_IN(SLEEP_PORT_CLOCK_GATE_IN), .SLEEP_MODE_IN(SLEEP_MODE_IN),
  .AUTO_CLOCK_GATING_ENABLE_IN(AUTO_CLOCK_GATING_ENABLE_IN),
  .DEEP_SLEEP_MODE_IN(DEEP_SLEEP_MODE_IN), .CAPABILITIES_1_IN(CAPABILITIES_1_IN),
  .PORT_ACCESS_IN(PORT_ACCESS_IN), .PORT_CLK_EN_OUT(PORT_CLK_EN_OUT),
  .PORT_FAULT_OUT(PORT_FAULT_OUT), .ADC0_RESET_OUT(ADC0_RESET_OUT),
  .WATCHDOG_RESET_OUT(WATCHDOG_RESET_OUT), .IRQ_OUT(IRQ_OUT));

// File: testbench.sv
// Self-checking bench for the port gate and soft reset block.
// Drives every input itself; a cycle model predicts each output.
`timescale 1ns/1ps
module testbench;
  import dsg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic auto_g = 1'b0, slp_m = 1'b0, deep_m = 1'b0, adc, wdt, irq, x_irq = 1'b0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, caps = '0, rdata, x_rd = '0, x_sr = '0, r;
  logic [4:0] run_g = '0, slp_g = '0, acc = '0, en, flt;
  logic [4:0] x_dg = '0, x_st = '0, x_mk = '0, x_en = '0, x_fl = '0;
  logic [11:0] tbl [8] = '{12'h040, 12'h128, 12'h200, 12'h204, 12'h208, 12'h3FC, 12'h128,
    12'h040};
  int failures = 0, total_checks = 0;
  int seed = 32'h5079E6F1;

  dsg_top u_dsg_top (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .RUN_PORT_CLOCK_GATE_IN(run_g),
    .SLEEP_PORT_CLOCK_GATE_IN(slp_g), .AUTO_CLOCK_GATING_ENABLE_IN(auto_g),
    .SLEEP_MODE_IN(slp_m), .DEEP_SLEEP_MODE_IN(deep_m), .CAPABILITIES_1_IN(caps),
    .PORT_ACCESS_IN(acc), .PORT_CLK_EN_OUT(en), .PORT_FAULT_OUT(flt),
    .ADC0_RESET_OUT(adc), .WATCHDOG_RESET_OUT(wdt), .IRQ_OUT(irq));

  // 100 MHz clock
  always #5 clk = ~clk;

  // One bus cycle, then the next edge
  task cyc(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
    wr <= w;
    rd <= s;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cycle model; old state is read before it is replaced
  always @(posedge clk) begin
    x_rd = '0;
    if (rd) begin
      case (addr)
        OFS_SOFT_RESET_0: x_rd = x_sr;
        OFS_DEEP_GATE: x_rd = {27'h0, x_dg};
        OFS_INT_STATUS: x_rd = {27'h0, x_st};
        OFS_INT_MASK: x_rd = {27'h0, x_mk};
        OFS_GATE_STATUS: x_rd = {27'h0, x_en};
        default: x_rd = '0;
      endcase
    end
    x_st = (x_st & ~((wr && addr == OFS_INT_STATUS) ? wdata[4:0] : 5'h00)) | x_fl;
    x_fl = acc & ~x_en;
    x_en = !auto_g ? run_g : deep_m ? x_dg : slp_m ? slp_g : run_g;
    if (wr && addr == OFS_DEEP_GATE) x_dg = wdata[4:0];
    if (wr && addr == OFS_INT_MASK) x_mk = wdata[4:0];
    if (wr && addr == OFS_SOFT_RESET_0) x_sr = ((x_sr & ~caps) | (wdata & caps))
      & SOFT_RESET_IMPL_MASK;
    x_irq = |(x_st & x_mk);
    if (!rst_n) {x_rd, x_sr, x_dg, x_st, x_mk, x_en, x_fl, x_irq} = '0;
  end

  // Compare every output with the model, reset included
  always @(negedge clk) begin
    check("clk_en", en, x_en);
    check("fault", flt, x_fl);
    check("adc_rst", adc, x_sr[ADC0_RST_POS]);
    check("wdt_rst", wdt, x_sr[WDT_RST_POS]);
    check("irq", irq, x_irq);
    check("rdata", rdata, x_rd);
  end

  // Bound on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude;
  end

  // Directed scenarios, then random traffic with a reset mid-run
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1'b0, 1'b0, '0, '0);
    for (int i = 0; i < 6; i++) cyc(1'b0, 1'b1, tbl[i], '0);
    cyc(1'b1, 1'b0, OFS_DEEP_GATE, 32'hFFFF_FFFF);
    cyc(1'b1, 1'b0, 12'h3FC, 32'hFFFF_FFFF);
    cyc(1'b0, 1'b1, OFS_DEEP_GATE, '0);
    cyc(1'b1, 1'b0, OFS_INT_MASK, 32'h0000_001F);
    auto_g <= 1'b1;
    deep_m <= 1'b1;
    acc <= 5'h1F;
    for (int i = 0; i < 5; i++) begin
      cyc(1'b1, 1'b0, OFS_DEEP_GATE, 32'h1 << i);
      cyc(1'b0, 1'b1, OFS_GATE_STATUS, '0);
    end
    acc <= 5'h00;
    // Let the last fault pulse drain so the clear really empties status
    cyc(1'b0, 1'b0, '0, '0);
    cyc(1'b1, 1'b0, OFS_INT_STATUS, 32'h0000_001F);
    cyc(1'b0, 1'b1, OFS_INT_STATUS, '0);
    for (int i = 0; i < 4; i++) begin
      caps <= {15'h0, i[1], 12'h0, i[0], 3'h0};
      cyc(1'b1, 1'b0, OFS_SOFT_RESET_0, 32'hFFFF_FFFF);
      cyc(1'b0, 1'b1, OFS_SOFT_RESET_0, '0);
    end
    cyc(1'b1, 1'b0, OFS_SOFT_RESET_0, '0);
    for (int k = 0; k < 600; k++) begin
      r = $random(seed);
      rst_n <= k < 300 || k > 302;
      run_g <= r[4:0];
      slp_g <= r[9:5];
      auto_g <= r[10];
      slp_m <= r[11];
      deep_m <= r[12] & r[13];
      acc <= r[18:14];
      caps <= $random(seed);
      cyc((k < 300 || k > 303) && r[22:21] == 2'h1, (k < 300 || k > 303) && r[22:21] == 2'h2,
        tbl[r[25:23]], $random(seed));
    end
    conclude;
  end
endmodule
